/* rtl/charger_ctrl.sv */
// Purpose: Charger control logic with AXI4-Lite register access
// Assumes: Detector inputs synchronous to i_ref_clk; flags latched upstream
// Notes:   Power stage and mode outputs are registered
`timescale 1ns/1ps
module charger_ctrl #(
    parameter int TIMER_WIDTH = charger_ctrl_pkg::TIMER_WIDTH
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]            i_awaddr,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    input  wire logic [7:0]            i_araddr,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready,
    // Detector and host inputs
    input  wire logic                  i_charge_enable_n,
    input  wire logic                  i_power_low,
    input  wire logic                  i_power_detected,
    input  wire logic                  i_input_overvoltage,
    input  wire logic                  i_below_recharge_threshold,
    input  wire logic                  i_below_precharge_threshold,
    input  wire logic                  i_timer_fault_latched,
    input  wire logic                  i_output_short_latched,
    input  wire logic                  i_termination_latched,
    input  wire logic                  i_battery_absent,
    input  wire logic                  i_pack_temp_bad,
    input  wire logic                  i_junction_over_regulation,
    input  wire logic                  i_thermal_shutdown,
    // Outputs
    output charger_ctrl_pkg::stage_t   o_stage,
    output charger_ctrl_pkg::mode_t    o_mode,
    output logic                       o_precharge_ref,
    output logic                       o_thermal_loop_active,
    output logic                       o_timer_running,
    output logic                       o_irq
);

    // ==========================================================
    // Registers and state
    logic [1:0]                          ctrl;
    logic [charger_ctrl_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [charger_ctrl_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic [TIMER_WIDTH-1:0]              timer;
    logic                                enable_n_prev;
    logic                                cycle_active;
    logic                                aw_held;
    logic                                w_held;
    logic [7:0]                          aw_addr;
    logic [31:0]                         w_data;
    logic [3:0]                          w_strb;

    // ==========================================================
    // Input qualification
    wire ts_present  = ctrl[charger_ctrl_pkg::CTRL_TS_PRES_BIT];
    wire timer_en    = ctrl[charger_ctrl_pkg::CTRL_TIMER_EN_BIT];
    wire temp_bad    = ts_present & i_pack_temp_bad;
    wire enable_fall = enable_n_prev & ~i_charge_enable_n;

    charger_ctrl_pkg::mode_t  next_mode;
    charger_ctrl_pkg::stage_t next_stage;

    // Mode decode consumes the latched flags directly
    charger_mode_decode u_decode (
        .i_enable_n          (i_charge_enable_n),
        .i_power_low         (i_power_low),
        .i_power_detected    (i_power_detected),
        .i_input_overvoltage (i_input_overvoltage),
        .i_timer_fault       (i_timer_fault_latched),
        .i_output_short      (i_output_short_latched),
        .i_termination       (i_termination_latched),
        .i_battery_absent    (i_battery_absent),
        .i_pack_temp_bad     (temp_bad),
        .i_thermal_shutdown  (i_thermal_shutdown),
        .o_mode              (next_mode),
        .o_stage             (next_stage)
    );

    // ==========================================================
    // Charge cycle start and timer control
    wire charging_ok = (next_mode == charger_ctrl_pkg::MODE_CHARGING);
    wire start_cycle = charging_ok & i_below_recharge_threshold
                       & (~cycle_active | enable_fall);
    wire in_standby  = (next_mode == charger_ctrl_pkg::MODE_STANDBY);
    wire in_suspend  = (next_mode == charger_ctrl_pkg::MODE_SUSPEND);
    wire timer_clear = in_standby | start_cycle | ~cycle_active;
    wire timer_count = cycle_active & charging_ok & timer_en;
    wire mode_change = (next_mode != o_mode);

    // Stage, mode and reference registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_stage               <= charger_ctrl_pkg::STAGE_OFF;
            o_mode                <= charger_ctrl_pkg::MODE_SLEEP;
            o_precharge_ref       <= 1'b0;
            o_thermal_loop_active <= 1'b0;
            enable_n_prev         <= 1'b1;
        end else begin
            o_stage               <= next_stage;
            o_mode                <= next_mode;
            o_precharge_ref       <= charging_ok & i_below_precharge_threshold;
            o_thermal_loop_active <= (next_stage == charger_ctrl_pkg::STAGE_ON)
                                     & i_junction_over_regulation;
            enable_n_prev         <= i_charge_enable_n;
        end
    end

    // Cycle tracking and safety timer
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cycle_active    <= 1'b0;
            timer           <= '0;
            o_timer_running <= 1'b0;
        end else begin
            if (start_cycle)
                cycle_active <= 1'b1;
            else if (in_standby || next_mode == charger_ctrl_pkg::MODE_SLEEP
                     || next_mode == charger_ctrl_pkg::MODE_POWER_DOWN)
                cycle_active <= 1'b0;
            if (timer_clear)
                timer <= '0;
            else if (timer_count)
                timer <= timer + 1'b1;
            // Suspend holds the count unchanged
            o_timer_running <= timer_count & ~start_cycle;
        end
    end

    // ==========================================================
    // AXI4-Lite write path
    wire do_write   = aw_held & w_held & ~o_bvalid;
    wire wr_ctrl    = do_write & (aw_addr == charger_ctrl_pkg::ADDR_CTRL);
    wire wr_enable  = do_write & (aw_addr == charger_ctrl_pkg::ADDR_IRQ_ENABLE);
    wire wr_clear   = do_write & (aw_addr == charger_ctrl_pkg::ADDR_IRQ_CLEAR);
    wire wr_mapped  = wr_ctrl | wr_enable | wr_clear;
    wire [charger_ctrl_pkg::IRQ_WIDTH-1:0] clear_bits =
        (wr_clear & w_strb[0]) ? w_data[charger_ctrl_pkg::IRQ_WIDTH-1:0] : '0;
    wire [charger_ctrl_pkg::IRQ_WIDTH-1:0] events = {
        next_stage == charger_ctrl_pkg::STAGE_FAULT,
        mode_change,
        start_cycle
    };

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= charger_ctrl_pkg::RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held   <= 1'b1;
                aw_addr   <= {i_awaddr[7:2], 2'b00};
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held   <= 1'b1;
                w_data   <= i_wdata;
                w_strb   <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_mapped ? charger_ctrl_pkg::RESP_OKAY : charger_ctrl_pkg::RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                aw_held   <= 1'b0;
                w_held    <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // Control, enable and sticky status; a new event wins over its clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl       <= charger_ctrl_pkg::CTRL_RESET;
            irq_enable <= charger_ctrl_pkg::IRQ_ENABLE_RESET;
            irq_status <= '0;
            o_irq      <= 1'b0;
        end else begin
            if (wr_ctrl && w_strb[0])
                ctrl <= w_data[1:0];
            if (wr_enable && w_strb[0])
                irq_enable <= w_data[charger_ctrl_pkg::IRQ_WIDTH-1:0];
            irq_status <= (irq_status & ~clear_bits) | events;
            o_irq      <= |(((irq_status & ~clear_bits) | events) & irq_enable);
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    wire [7:0]  rd_addr = {i_araddr[7:2], 2'b00};
    wire        rd_hit  = (rd_addr == charger_ctrl_pkg::ADDR_CTRL)
                        | (rd_addr == charger_ctrl_pkg::ADDR_STATE)
                        | (rd_addr == charger_ctrl_pkg::ADDR_IRQ_STATUS)
                        | (rd_addr == charger_ctrl_pkg::ADDR_IRQ_ENABLE)
                        | (rd_addr == charger_ctrl_pkg::ADDR_IRQ_CLEAR)
                        | (rd_addr == charger_ctrl_pkg::ADDR_TIMER);
    wire [31:0] state_word = {24'h000000, o_thermal_loop_active, o_precharge_ref, cycle_active,
                              o_mode, o_stage};
    wire [31:0] rd_value =
        (rd_addr == charger_ctrl_pkg::ADDR_CTRL)       ? {30'h0, ctrl} :
        (rd_addr == charger_ctrl_pkg::ADDR_STATE)      ? state_word :
        (rd_addr == charger_ctrl_pkg::ADDR_IRQ_STATUS) ? {29'h0, irq_status} :
        (rd_addr == charger_ctrl_pkg::ADDR_IRQ_ENABLE) ? {29'h0, irq_enable} :
        (rd_addr == charger_ctrl_pkg::ADDR_TIMER)      ? 32'(timer) : 32'h0000_0000;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= charger_ctrl_pkg::RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rdata   <= rd_value;
                o_rresp   <= rd_hit ? charger_ctrl_pkg::RESP_OKAY : charger_ctrl_pkg::RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid  <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    a_off_when_sleep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(i_power_detected) |-> o_stage == charger_ctrl_pkg::STAGE_OFF)
        else $error("Stage not off in sleep");
    a_standby_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($past(i_charge_enable_n) && $past(i_power_detected) && !$past(i_power_low))
        |-> o_mode == charger_ctrl_pkg::MODE_STANDBY && o_stage == charger_ctrl_pkg::STAGE_OFF)
        else $error("Standby not reached with enable high");
    a_on_needs_ok: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_stage == charger_ctrl_pkg::STAGE_ON |-> !$past(i_thermal_shutdown)
        && !$past(i_output_short_latched) && !$past(i_timer_fault_latched) && !$past(i_termination_latched))
        else $error("Stage on with a fault present");
    a_short_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(i_output_short_latched) |-> o_stage != charger_ctrl_pkg::STAGE_ON)
        else $error("Stage on during short");
    a_standby_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        in_standby |=> timer == '0)
        else $error("Timer not cleared in standby");
    a_suspend_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        in_suspend && cycle_active && !start_cycle |=> $stable(timer))
        else $error("Timer moved in suspend");
    a_fault_stage: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!i_charge_enable_n && i_power_detected && !i_power_low && !i_input_overvoltage
         && !i_output_short_latched && !i_termination_latched && i_timer_fault_latched)
        |=> o_stage == charger_ctrl_pkg::STAGE_FAULT)
        else $error("Fault current not selected");
    a_start_needs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        start_cycle |-> !i_charge_enable_n && i_power_detected && i_below_recharge_threshold)
        else $error("Cycle started without conditions");
    a_precharge_ref: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_precharge_ref == (o_mode == charger_ctrl_pkg::MODE_CHARGING && $past(i_below_precharge_threshold)))
        else $error("Precharge reference wrong");

endmodule

/* rtl/charger_ctrl_pkg.sv */
// Purpose: Shared constants and types for the charger control logic
// Assumes: 100 MHz reference clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package charger_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATE      = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
    localparam logic [7:0] ADDR_TIMER      = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CTRL_TIMER_EN_BIT = 0;
    localparam int CTRL_TS_PRES_BIT  = 1;
    localparam int IRQ_START_BIT     = 0;
    localparam int IRQ_MODE_BIT      = 1;
    localparam int IRQ_FAULT_BIT     = 2;
    localparam int IRQ_WIDTH         = 3;

    // ==========================================================
    // Reset values
    localparam logic [1:0] CTRL_RESET       = 2'h3;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

    // ==========================================================
    // Timing: precharge current is one tenth of fast charge
    localparam int PRECHG_DIVISOR = 10;
    localparam int TIMER_WIDTH    = 32;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_POWER_DOWN = 3'b000,
        MODE_SLEEP      = 3'b001,
        MODE_STANDBY    = 3'b010,
        MODE_SUSPEND    = 3'b011,
        MODE_CHARGING   = 3'b100
    } mode_t;

    // Power stage commands
    typedef enum logic [1:0] {
        STAGE_OFF    = 2'b00,
        STAGE_ON     = 2'b01,
        STAGE_FAULT  = 2'b10,
        STAGE_DETECT = 2'b11
    } stage_t;

endpackage

/* rtl/charger_mode_decode.sv */
// Purpose: Combinational mode and power stage decode
// Assumes: Fault, termination and short flags arrive already latched
// Notes:   Pure logic; the caller registers the results
`timescale 1ns/1ps
module charger_mode_decode (
    input  wire logic                            i_enable_n,
    input  wire logic                            i_power_low,
    input  wire logic                            i_power_detected,
    input  wire logic                            i_input_overvoltage,
    input  wire logic                            i_timer_fault,
    input  wire logic                            i_output_short,
    input  wire logic                            i_termination,
    input  wire logic                            i_battery_absent,
    input  wire logic                            i_pack_temp_bad,
    input  wire logic                            i_thermal_shutdown,
    output charger_ctrl_pkg::mode_t              o_mode,
    output charger_ctrl_pkg::stage_t             o_stage
);

    // ==========================================================
    // Mode and stage selection, in priority order
    wire power_down = ~i_enable_n & i_power_low;
    wire sleep      = ~i_power_detected;
    wire standby    = i_enable_n | i_input_overvoltage;
    wire all_ok     = ~i_timer_fault & ~i_output_short & ~i_termination & ~i_battery_absent
                      & ~i_pack_temp_bad & ~i_thermal_shutdown;

    always_comb begin
        if (power_down) begin
            o_mode  = charger_ctrl_pkg::MODE_POWER_DOWN;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else if (sleep) begin
            o_mode  = charger_ctrl_pkg::MODE_SLEEP;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else if (standby) begin
            o_mode  = charger_ctrl_pkg::MODE_STANDBY;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else if (i_output_short) begin
            o_mode  = charger_ctrl_pkg::MODE_SUSPEND;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else if (i_termination) begin
            o_mode  = charger_ctrl_pkg::MODE_SUSPEND;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else if (i_timer_fault) begin
            o_mode  = charger_ctrl_pkg::MODE_SUSPEND;
            o_stage = charger_ctrl_pkg::STAGE_FAULT;
        end else if (i_battery_absent) begin
            o_mode  = charger_ctrl_pkg::MODE_SUSPEND;
            o_stage = charger_ctrl_pkg::STAGE_DETECT;
        end else if (!all_ok) begin
            o_mode  = charger_ctrl_pkg::MODE_SUSPEND;
            o_stage = charger_ctrl_pkg::STAGE_OFF;
        end else begin
            o_mode  = charger_ctrl_pkg::MODE_CHARGING;
            o_stage = charger_ctrl_pkg::STAGE_ON;
        end
    end

endmodule

/* tb/charger_partner.sv */
// Purpose: Host enable pin and detector model facing the charger control
// Assumes: Fault, termination and short flags are held latched here
// Notes:   Levels change just after a rising edge
`timescale 1ns/1ps
module charger_partner (
    input  wire logic        i_ref_clk,
    input  wire logic [12:0] i_want,
    output logic      [12:0] o_det
);
    // ==========================================
    // Host enable and latched detector flags
    initial o_det = 13'h1000;
    always @(posedge i_ref_clk) begin
        o_det <= i_want;
    end
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the charger control logic
// Assumes: Detector levels come from the partner model
// Notes:   Bit order of want: enable_n down to thermal_shutdown
`timescale 1ns/1ps
module testbench;
    localparam logic [12:0] GOOD = 13'h0500;
    localparam logic [1:0] OFF = charger_ctrl_pkg::STAGE_OFF, ON = charger_ctrl_pkg::STAGE_ON;
    localparam logic [1:0] FLT = charger_ctrl_pkg::STAGE_FAULT, DET = charger_ctrl_pkg::STAGE_DETECT;
    localparam logic [2:0] PD = charger_ctrl_pkg::MODE_POWER_DOWN, SL = charger_ctrl_pkg::MODE_SLEEP;
    localparam logic [2:0] SB = charger_ctrl_pkg::MODE_STANDBY, SU = charger_ctrl_pkg::MODE_SUSPEND;
    localparam logic [2:0] CH = charger_ctrl_pkg::MODE_CHARGING;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd, t1;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] o_bresp, o_rresp, rs;
    logic o_precharge_ref, o_thermal_loop_active, o_timer_running, o_irq;
    charger_ctrl_pkg::stage_t o_stage;
    charger_ctrl_pkg::mode_t  o_mode;
    logic i_charge_enable_n, i_power_low, i_power_detected, i_input_overvoltage, i_below_recharge_threshold;
    logic i_below_precharge_threshold, i_timer_fault_latched, i_output_short_latched, i_termination_latched;
    logic i_battery_absent, i_pack_temp_bad, i_junction_over_regulation, i_thermal_shutdown;
    logic [12:0] want = 13'h1000, det;
    int fails = 0, comparisons = 0, cycles = 0;

    // Unpack detector levels onto the design inputs
    assign {i_charge_enable_n, i_power_low, i_power_detected, i_input_overvoltage, i_below_recharge_threshold,
            i_below_precharge_threshold, i_timer_fault_latched, i_output_short_latched, i_termination_latched,
            i_battery_absent, i_pack_temp_bad, i_junction_over_regulation, i_thermal_shutdown} = det;
    charger_partner i_charger_partner (.i_ref_clk(i_ref_clk), .i_want(want), .o_det(det));
    charger_ctrl i_charger_ctrl (.*);

    // ==========================================
    // Clock and hang guard
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // AXI write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        rs = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        rd = o_rdata;
        rs = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // Apply detector levels, then judge mode and stage
    task automatic go(input logic [12:0] v, input logic [4:0] e);
        want <= v;
        repeat (3) @(posedge i_ref_clk);
        chk({27'h0, o_mode, o_stage}, {27'h0, e});
    endtask

    task automatic t_modes;
        logic [12:0] v[11] = '{13'h1000, 13'h0400, 13'h0800, 13'h0000, 13'h0200, 13'h0020,
                               13'h0010, 13'h0040, 13'h0008, 13'h0004, 13'h0001};
        logic [4:0] e[11] = '{{SB, OFF}, {SL, OFF}, {PD, OFF}, {CH, ON}, {SB, OFF}, {SU, OFF},
                              {SU, OFF}, {SU, FLT}, {SU, DET}, {SU, OFF}, {SU, OFF}};
        for (int i = 0; i < 11; i++) begin
            go(GOOD ^ v[i], e[i]);
        end
    endtask
    task automatic t_current;
        go(GOOD | 13'h0080, {CH, ON});
        chk({31'h0, o_precharge_ref}, 32'h1);
        go(GOOD | 13'h0002, {CH, ON});
        chk({31'h0, o_thermal_loop_active}, 32'h1);
        rd_reg(charger_ctrl_pkg::ADDR_STATE);
        chk(rd, 32'h0000_00b1);
    endtask
    task automatic t_timer;
        go(GOOD ^ 13'h1000, {SB, OFF});
        wr(charger_ctrl_pkg::ADDR_IRQ_CLEAR, 32'h7);
        go(GOOD, {CH, ON});
        rd_reg(charger_ctrl_pkg::ADDR_IRQ_STATUS);
        chk({31'h0, rd[0]}, 32'h1);
        chk({31'h0, o_timer_running}, 32'h1);
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        t1 = rd;
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        chk({31'h0, rd > t1}, 32'h1);
        go(GOOD | 13'h0004, {SU, OFF});
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        t1 = rd;
        repeat (5) @(posedge i_ref_clk);
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        chk(rd, t1);
        go(GOOD, {CH, ON});
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        chk({31'h0, rd > t1}, 32'h1);
        go(GOOD ^ 13'h1000, {SB, OFF});
        rd_reg(charger_ctrl_pkg::ADDR_TIMER);
        chk(rd, 32'h0);
    endtask
    task automatic t_thermistor;
        wr(charger_ctrl_pkg::ADDR_CTRL, 32'h1);
        go(GOOD | 13'h0004, {CH, ON});
        wr(charger_ctrl_pkg::ADDR_CTRL, 32'h3);
        go(GOOD | 13'h0004, {SU, OFF});
        wr(charger_ctrl_pkg::ADDR_CTRL, 32'h2);
        go(GOOD, {CH, ON});
        chk({31'h0, o_timer_running}, 32'h0);
    endtask
    task automatic t_irq;
        rd_reg(charger_ctrl_pkg::ADDR_IRQ_ENABLE);
        chk(rd, {29'h0, charger_ctrl_pkg::IRQ_ENABLE_RESET});
        rd_reg(8'h40);
        chk({30'h0, rs}, {30'h0, charger_ctrl_pkg::RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk({30'h0, rs}, {30'h0, charger_ctrl_pkg::RESP_SLVERR});
        wr(charger_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h4);
        go(GOOD | 13'h0040, {SU, FLT});
        wr(charger_ctrl_pkg::ADDR_IRQ_CLEAR, 32'h4);
        chk({31'h0, o_irq}, 32'h1);
        go(GOOD, {CH, ON});
        wr(charger_ctrl_pkg::ADDR_IRQ_CLEAR, 32'h4);
        @(posedge i_ref_clk);
        chk({31'h0, o_irq}, 32'h0);
        go(GOOD | 13'h0040, {SU, FLT});
        wr(charger_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h0);
        @(posedge i_ref_clk);
        chk({31'h0, o_irq}, 32'h0);
        rd_reg(charger_ctrl_pkg::ADDR_IRQ_STATUS);
        chk({31'h0, rd[2]}, 32'h1);
    endtask

    task automatic wrap_up;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        rd_reg(charger_ctrl_pkg::ADDR_CTRL);
        chk(rd, {30'h0, charger_ctrl_pkg::CTRL_RESET});
        t_modes();
        t_current();
        t_timer();
        t_thermistor();
        t_irq();
        wrap_up();
    end
endmodule
